//--- hw/qpb_sram_ctrl.sv
// Read/write burst control with write buffers, storage array and read FIFO
`timescale 1ns/1ps

module qpb_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready_o = (count != CW'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule : qpb_fifo

module qpb_sram_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire logic [qpb_pkg::ADDR_W-1:0] rd_addr_i,
    input wire logic [qpb_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [qpb_pkg::DATA_W-1:0] d_rise_i,
    input wire logic [qpb_pkg::DATA_W-1:0] d_fall_i,
    input wire logic [qpb_pkg::LANES-1:0] write_mask_n_rise_i,
    input wire logic [qpb_pkg::LANES-1:0] write_mask_n_fall_i,
    input wire logic rd_ready_i,
    output logic [qpb_pkg::DATA_W-1:0] q_rise_o,
    output logic [qpb_pkg::DATA_W-1:0] q_fall_o,
    output logic q_oe_n_o,
    output logic read_data_valid_o
);
    import qpb_pkg::*;

    qpb_port_state_type rd_state;
    qpb_port_state_type wr_state;
    logic idle_prev;
    logic rd_accept;
    logic wr_accept;
    logic rd_room;
    logic [RD_STAGES-1:0] rd_pv;
    logic [ADDR_W-1:0] rd_pa [RD_STAGES];
    logic [WR_STAGES-1:0] wr_pv;
    logic [ADDR_W-1:0] wr_pa [WR_STAGES];
    logic [DATA_W-1:0] array_mem [ARRAY_DEPTH];
    logic [DATA_W-1:0] stg_data [BEATS/2];
    logic [LANES-1:0] stg_mask_n [BEATS/2];
    logic [WBUF-1:0] buf_valid;
    logic [ADDR_W-1:0] buf_addr [WBUF];
    logic [DATA_W-1:0] buf_data [WBUF][BEATS];
    logic [LANES-1:0] buf_mask_n [WBUF][BEATS];
    logic wr_done;
    logic [WORD_W-1:0] commit_word [BEATS];
    logic fifo_in_valid;
    logic [PAIR_W-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [PAIR_W-1:0] fifo_out_data;
    logic [LEVEL_W-1:0] fifo_level;
    logic [BEAT_W-1:0] pair_beat;
    logic [ADDR_W-1:0] pair_addr;

    // Linear burst word address: base then +1, +2, +3
    function automatic logic [WORD_W-1:0] burst_word(input logic [ADDR_W-1:0] base,
                                                     input logic [BEAT_W-1:0] beat);
        burst_word = {base, {BEAT_W{1'b0}}} + WORD_W'(beat);
    endfunction : burst_word

    // Coherent read: newest buffer lane, then older buffer, then array
    function automatic logic [DATA_W-1:0] read_word(input logic [WORD_W-1:0] wa);
        logic [DATA_W-1:0] w;
        w = array_mem[wa[ARRAY_AW-1:0]];
        for (int b = WBUF - 1; b >= 0; b--) begin
            if (buf_valid[b] && buf_addr[b] == wa[WORD_W-1:BEAT_W]) begin
                for (int l = 0; l < LANES; l++) begin
                    if (!buf_mask_n[b][wa[BEAT_W-1:0]][l]) begin
                        w[l*LANE_W +: LANE_W] = buf_data[b][wa[BEAT_W-1:0]][l*LANE_W +: LANE_W];
                    end
                end
            end
        end
        read_word = w;
    endfunction : read_word

    // Command acceptance; a refused read still clears idle_prev and can block a write
    assign rd_room = (fifo_level <= LEVEL_W'(FIFO_DEPTH) - RD_ROOM_LEVEL);
    assign rd_accept = !rd_sel_n_i && rd_state == PORT_IDLE && rd_room;
    assign wr_accept = !wr_sel_n_i && wr_state == PORT_IDLE
                       && !(idle_prev && !rd_sel_n_i);
    assign wr_done = wr_pv[WR_STAGES-1];

    // Idle-cycle tracker for read-over-write priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_prev <= 1'b1;
        end else begin
            idle_prev <= rd_sel_n_i & wr_sel_n_i;
        end
    end

    // Read machine: a burst blocks the very next edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_state <= PORT_IDLE;
        end else begin
            unique case (rd_state)
                PORT_IDLE: begin
                    if (rd_accept) begin
                        rd_state <= PORT_BURST;
                    end
                end
                PORT_BURST: begin
                    rd_state <= PORT_IDLE;
                end
            endcase
        end
    end

    // Write machine, independent of the read one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_state <= PORT_IDLE;
        end else begin
            unique case (wr_state)
                PORT_IDLE: begin
                    if (wr_accept) begin
                        wr_state <= PORT_BURST;
                    end
                end
                PORT_BURST: begin
                    wr_state <= PORT_IDLE;
                end
            endcase
        end
    end

    // Read and write latency pipelines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_pv <= '0;
            wr_pv <= '0;
        end else begin
            rd_pv <= {rd_pv[RD_STAGES-2:0], rd_accept};
            wr_pv <= {wr_pv[WR_STAGES-2:0], wr_accept};
        end
    end

    // Burst address follows its command down the pipelines
    always_ff @(posedge clk_i) begin
        rd_pa[0] <= rd_addr_i;
        wr_pa[0] <= wr_addr_i;
        for (int i = 1; i < RD_STAGES; i++) begin
            rd_pa[i] <= rd_pa[i-1];
        end
        for (int i = 1; i < WR_STAGES; i++) begin
            wr_pa[i] <= wr_pa[i-1];
        end
    end

    // First write pair waits here; the second goes straight to the buffer
    always_ff @(posedge clk_i) begin
        if (wr_pv[WR_STAGES-2]) begin
            stg_data[0] <= d_rise_i;
            stg_data[1] <= d_fall_i;
            stg_mask_n[0] <= write_mask_n_rise_i;
            stg_mask_n[1] <= write_mask_n_fall_i;
        end
    end

    // Two-deep write buffer; newest in slot 0
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_valid <= '0;
        end else if (wr_done) begin
            buf_valid <= {buf_valid[0], 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_done) begin
            buf_addr[1] <= buf_addr[0];
            buf_addr[0] <= wr_pa[WR_STAGES-1];
            for (int k = 0; k < BEATS; k++) begin
                buf_data[1][k] <= buf_data[0][k];
                buf_mask_n[1][k] <= buf_mask_n[0][k];
            end
            buf_data[0][0] <= stg_data[0];
            buf_data[0][1] <= stg_data[1];
            buf_data[0][2] <= d_rise_i;
            buf_data[0][3] <= d_fall_i;
            buf_mask_n[0][0] <= stg_mask_n[0];
            buf_mask_n[0][1] <= stg_mask_n[1];
            buf_mask_n[0][2] <= write_mask_n_rise_i;
            buf_mask_n[0][3] <= write_mask_n_fall_i;
        end
    end

    // Commit of the oldest buffered burst on each write from the third on
    generate
        for (genvar g = 0; g < BEATS; g++) begin : g_commit
            assign commit_word[g] = burst_word(buf_addr[1], BEAT_W'(g));
        end
    endgenerate
    // One process owns the array, so every lane write has a single driver
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < BEATS; k++) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_done && buf_valid[1] && !buf_mask_n[1][k][l]) begin
                    array_mem[commit_word[k][ARRAY_AW-1:0]][l*LANE_W +: LANE_W] <=
                        buf_data[1][k][l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Read pairs enter the FIFO two and three edges after the command
    assign pair_beat = rd_pv[RD_STAGES-1] ? BEAT_W'(2) : BEAT_W'(0);
    assign pair_addr = rd_pv[RD_STAGES-1] ? rd_pa[RD_STAGES-1] : rd_pa[RD_STAGES-2];
    assign fifo_in_valid = rd_pv[RD_STAGES-1] | rd_pv[RD_STAGES-2];
    always_comb begin
        fifo_in_data = {read_word(burst_word(pair_addr, pair_beat + 1'b1)),
                        read_word(burst_word(pair_addr, pair_beat))};
    end
    assign fifo_out_ready = !read_data_valid_o || rd_ready_i;

    qpb_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data),
        .level_o(fifo_level)
    );

    // Output register; holds its value while nothing moves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_data_valid_o <= 1'b0;
            q_oe_n_o <= 1'b1;
            q_rise_o <= '0;
            q_fall_o <= '0;
        end else if (fifo_out_ready) begin
            read_data_valid_o <= fifo_out_valid;
            q_oe_n_o <= !fifo_out_valid;
            if (fifo_out_valid) begin
                q_fall_o <= fifo_out_data[DATA_W-1:0];
                q_rise_o <= fifo_out_data[PAIR_W-1:DATA_W];
            end
        end
    end
endmodule : qpb_sram_ctrl

//--- hw/qpb_pkg.sv
// Constants, types and functional notes for the burst-of-four SRAM control block
package qpb_pkg;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 20;
    localparam int BEATS = 4;
    localparam int BEAT_W = 2;
    localparam int WORD_W = ADDR_W + BEAT_W;
    localparam int ARRAY_AW = 8;
    localparam int ARRAY_DEPTH = 256;
    localparam int PAIR_W = 2 * DATA_W;
    localparam int FIFO_DEPTH = 8;
    localparam int LEVEL_W = 4;
    // Free slots a read needs: its own two pairs plus one burst in flight
    localparam logic [LEVEL_W-1:0] RD_ROOM_LEVEL = 4'h4;
    localparam int RD_STAGES = 3;
    localparam int WR_STAGES = 4;
    localparam int WBUF = 2;
    localparam int CLK_PERIOD_NS = 10;

    typedef enum logic [1:0] {
        PORT_IDLE = 2'b01,
        PORT_BURST = 2'b10
    } qpb_port_state_type;
endpackage : qpb_pkg

//--- testbench/qpb_sram_ctrl_asserts.sv
// Port-level assertions for the burst-of-four SRAM control block
`timescale 1ns/1ps
module qpb_sram_ctrl_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_sel_n_i,
    input wire logic rd_ready_i,
    input wire logic [qpb_pkg::DATA_W-1:0] q_rise_o,
    input wire logic [qpb_pkg::DATA_W-1:0] q_fall_o,
    input wire logic q_oe_n_o,
    input wire logic read_data_valid_o
);
    import qpb_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Read taken with output empty, then drained with no new read on the next two edges
    sequence s_rd_cmd;
        rd_sel_n_i ##1 !rd_sel_n_i && !read_data_valid_o;
    endsequence
    sequence s_rd_drain;
        (rd_sel_n_i && rd_ready_i) [*2] ##1 rd_ready_i [*3];
    endsequence
    sequence s_no_read;
        rd_sel_n_i [*4];
    endsequence
    // Output pair framing and holding
    a_oe_follows_valid: assert property (q_oe_n_o == !read_data_valid_o)
        else $error("output enable disagrees with valid");
    a_valid_after_read: assert property ($rose(read_data_valid_o) |-> $past(rd_sel_n_i, 4) == 1'h0)
        else $error("valid rose without a read four edges back");
    a_valid_two_pairs: assert property ($rose(read_data_valid_o) ##0 rd_ready_i |=> read_data_valid_o)
        else $error("second pair missing");
    a_rd_burst_frame: assert property (s_rd_cmd ##1 s_rd_drain |-> read_data_valid_o && $past(read_data_valid_o) ##1 !read_data_valid_o)
        else $error("read burst not framed by two valid pairs");
    a_quiet_no_data: assert property (s_no_read ##0 !read_data_valid_o |=> !read_data_valid_o)
        else $error("valid without a read");
    a_pair_holds: assert property (read_data_valid_o && !rd_ready_i |=> read_data_valid_o && $stable(q_rise_o) && $stable(q_fall_o))
        else $error("stalled pair changed");
    a_idle_holds: assert property (!read_data_valid_o ##1 !read_data_valid_o |-> $stable(q_rise_o) && $stable(q_fall_o))
        else $error("idle output changed");
    a_reset_clear: assert property ($fell(rst_i) |-> !read_data_valid_o && q_oe_n_o && q_rise_o == '0 && q_fall_o == '0)
        else $error("outputs not cleared by reset");
endmodule : qpb_sram_ctrl_asserts

bind qpb_sram_ctrl qpb_sram_ctrl_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_sel_n_i(rd_sel_n_i),
    .rd_ready_i(rd_ready_i), .q_rise_o(q_rise_o), .q_fall_o(q_fall_o), .q_oe_n_o(q_oe_n_o),
    .read_data_valid_o(read_data_valid_o));

//--- testbench/qpb_ctrl_model.sv
// Memory controller model: commands, write beats and read ready
`timescale 1ns/1ps
module qpb_ctrl_model (
    output logic rd_sel_n_o,
    output logic wr_sel_n_o,
    output logic [qpb_pkg::ADDR_W-1:0] rd_addr_o,
    output logic [qpb_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [qpb_pkg::DATA_W-1:0] d_rise_o,
    output logic [qpb_pkg::DATA_W-1:0] d_fall_o,
    output logic [qpb_pkg::LANES-1:0] mask_rise_o,
    output logic [qpb_pkg::LANES-1:0] mask_fall_o,
    output logic rd_ready_o
);
    import qpb_pkg::*;
    int cyc = 0;
    logic [39:0] slot [int];
    // One cycle of activity, called just after a falling edge
    task automatic step(input logic rn, input logic wn, input logic [ADDR_W-1:0] ra,
                        input logic [ADDR_W-1:0] wa, input logic [71:0] wd,
                        input logic [7:0] wm, input logic rdy);
        cyc++;
        rd_sel_n_o = rn;
        wr_sel_n_o = wn;
        rd_addr_o = ra;
        wr_addr_o = wa;
        rd_ready_o = rdy;
        // Beats three and four edges on, only one burst per slot
        if (!wn && !slot.exists(cyc + 3)) begin
            slot[cyc + 3] = {wm[3:0], wd[35:0]};
            slot[cyc + 4] = {wm[7:4], wd[71:36]};
        end
        // Idle data lines carry changing junk
        {mask_fall_o, mask_rise_o, d_fall_o, d_rise_o} = slot.exists(cyc) ? slot[cyc] : {wm[3:0], ~wd[35:0]};
    endtask : step
endmodule : qpb_ctrl_model

//--- testbench/quad_port_burst4_sram_control_tb.sv
// Self-checking bench for the burst-of-four SRAM control block
`timescale 1ns/1ps
module quad_port_burst4_sram_control_tb;
    import qpb_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic rd_sel_n, wr_sel_n, rd_ready, q_oe_n, valid, stall = 1'h0;
    logic last_rd = 1'h0, last_wr = 1'h0, was_idle = 1'h1;
    logic [ADDR_W-1:0] rd_addr, wr_addr;
    logic [DATA_W-1:0] d_rise, d_fall, q_rise, q_fall;
    logic [LANES-1:0] m_rise, m_fall;
    logic [DATA_W-1:0] mem [ARRAY_DEPTH];
    logic [PAIR_W-1:0] expq [$];
    logic [31:0] seed = 32'h000162bd;
    logic [31:0] base;
    int failures = 0;
    int checks = 0;
    qpb_ctrl_model ctrl (.rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n), .rd_addr_o(rd_addr),
        .wr_addr_o(wr_addr), .d_rise_o(d_rise), .d_fall_o(d_fall), .mask_rise_o(m_rise),
        .mask_fall_o(m_fall), .rd_ready_o(rd_ready));
    qpb_sram_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n),
        .rd_addr_i(rd_addr), .wr_addr_i(wr_addr), .d_rise_i(d_rise), .d_fall_i(d_fall),
        .write_mask_n_rise_i(m_rise), .write_mask_n_fall_i(m_fall), .rd_ready_i(rd_ready),
        .q_rise_o(q_rise), .q_fall_o(q_fall), .q_oe_n_o(q_oe_n), .read_data_valid_o(valid));
    // Clock and hang guard
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        close_out();
    end
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd
    task automatic chk(input string what, input logic [PAIR_W-1:0] exp, input logic [PAIR_W-1:0] got);
        checks++;
        if (exp !== got) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One cycle: score the pair, update the model, drive the command
    task automatic tick(input logic rn, input logic wn, input logic [31:0] a, input logic [7:0] wm);
        logic [95:0] wd;
        logic rd_ok, wr_ok, rdy;
        logic [7:0] idx;
        @(negedge clk_i);
        wd = {rnd(), rnd(), rnd()};
        rdy = stall ? |wd[95:94] : 1'h1;
        if (valid === 1'h1 && rdy) chk("read pair", expq.size() > 0 ? expq.pop_front() : 'x, {q_rise, q_fall});
        rd_ok = !rn && !last_rd;
        wr_ok = !wn && !last_wr && !(!rn && was_idle);
        for (int k = 0; k < BEATS; k++) begin
            idx = {a[5:0], k[1:0]};
            if (rd_ok && k[0]) expq.push_back({mem[idx], mem[idx - 8'h01]});
            if (wr_ok && !wm[2*k]) mem[idx][8:0] = wd[18*k +: 9];
            if (wr_ok && !wm[2*k+1]) mem[idx][17:9] = wd[18*k+9 +: 9];
        end
        last_rd = rd_ok;
        last_wr = wr_ok;
        was_idle = rn && wn;
        ctrl.step(rn, wn, a[ADDR_W-1:0], a[ADDR_W-1:0], wd[71:0], wm, rdy);
    endtask : tick
    task automatic idle(input int n);
        repeat (n) tick(1'h1, 1'h1, rnd(), 8'h00);
    endtask : idle
    task automatic wr(input logic [31:0] a, input logic [7:0] wm);
        tick(1'h1, 1'h0, a, wm);
        idle(3);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        for (int i = 0; i < 20 && expq.size() > 4; i++) idle(1);
        if (expq.size() > 4) begin
            failures++;
            $display("mismatch read room expected 4 seen %0d", expq.size());
            close_out();
        end
        tick(1'h0, 1'h1, a, 8'h00);
        idle(1);
    endtask : rd
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    initial begin
        ctrl.step(1'h1, 1'h1, '0, '0, '0, 8'hff, 1'h1);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'h0;
        base = rnd();
        // Fill three bursts and read them back
        for (int i = 0; i < 3; i++) wr(base + 32'(i), 8'h00);
        for (int i = 0; i < 3; i++) rd(base + 32'(i));
        // Per-beat masks with an aborted beat, then a fully masked burst
        wr(base, 8'h1b);
        wr(base + 32'h1, 8'hff);
        rd(base);
        rd(base + 32'h1);
        // Read at t, write at t+1
        tick(1'h0, 1'h1, base, 8'h00);
        tick(1'h1, 1'h0, base + 32'h2, 8'h00);
        idle(3);
        rd(base + 32'h2);
        // Same-port commands on consecutive edges
        tick(1'h0, 1'h1, base, 8'h00);
        tick(1'h0, 1'h1, base + 32'h1, 8'h00);
        tick(1'h1, 1'h0, base, 8'h00);
        tick(1'h1, 1'h0, base + 32'h1, 8'h00);
        // Both selects low after an idle edge
        idle(1);
        tick(1'h0, 1'h0, base + 32'h1, 8'h00);
        idle(3);
        rd(base + 32'h1);
        rd(base);
        // Reads queue up behind a stalling consumer
        stall = 1'h1;
        for (int i = 0; i < 12; i++) rd(base + 32'(i % 3));
        stall = 1'h0;
        for (int i = 0; i < 60 && expq.size() > 0; i++) idle(1);
        idle(6);
        // A lone read from a quiet port, framed by exactly two pairs
        rd(base);
        idle(6);
        chk("pairs left", '0, PAIR_W'(expq.size()));
        close_out();
    end
endmodule : quad_port_burst4_sram_control_tb
